// File: logic/irq_combiner_cfg.svh
// Constants for the dual-level interrupt combiner
// Function
// [R1] All sources are merged onto a critical and a non-critical request, each source routed by software.
// [R2] Each source is level sensitive or edge sensitive with a latch held until cleared, by software choice.
// [R3] Each source has a programmable active polarity: high or low for level, rising or falling for edge.
// [R4] A read-only vector is formed from a written base and the position of the top enabled active critical source.
// [R5] A priority bit chooses whether the least or most significant status bit wins vector selection.
// [R6] Bit positions count from the most significant bit as zero to the least significant as thirty-one.
// [R7] Only enabled sources reach a request line or the vector; raw state shows in status regardless.
`ifndef IRQ_COMBINER_CFG_SVH
`define IRQ_COMBINER_CFG_SVH
//----------------------------------------
// Register offsets (byte addresses)
//----------------------------------------
`define IC_STATUS_OFS   8'h00
`define IC_ENABLE_OFS   8'h04
`define IC_CRIT_OFS     8'h08
`define IC_EDGE_OFS     8'h0c
`define IC_POL_OFS      8'h10
`define IC_VBASE_OFS    8'h14
`define IC_VEC_OFS      8'h18
`define IC_CTRL_OFS     8'h1c
`define IC_PEND_OFS     8'h20
`define IC_PMASK_OFS    8'h24
//----------------------------------------
// Fields and reset values
//----------------------------------------
`define IC_CTRL_PRIO_BIT 0
`define IC_VEC_SHIFT     2
`define IC_ZERO_RST      32'h0000_0000
`define IC_POL_RST       32'hffff_ffff
`endif

// File: logic/irq_combiner_pkg.sv
// Types for the dual-level interrupt combiner
package irq_combiner_pkg;
   typedef logic [31:0] word_t;
   typedef logic [4:0]  pos_t;
endpackage

// File: logic/irq_prio_if.sv
// Carrier between the combiner and its priority encoder
`timescale 1ns/1ns
interface irq_prio_if;
   irq_combiner_pkg::word_t req;
   logic                    lsb_first;
   logic                    hit;
   irq_combiner_pkg::pos_t  pos;
   modport enc (input req, input lsb_first, output hit, output pos);
   modport use_side (output req, output lsb_first, input hit, input pos);
endinterface

// File: logic/irq_prio_enc.sv
// Priority encoder with selectable winning end
`timescale 1ns/1ns
module irq_prio_enc (
   irq_prio_if.enc p
);
   //----------------------------------------
   // Search
   //----------------------------------------
   // Position p counts from the MSB as zero, vector bit is 31-p
   always_comb begin
      p.hit = |p.req;
      p.pos = 5'h00;
      if (p.lsb_first) begin
         for (int i = 31; i >= 0; i--) begin
            if (p.req[i]) p.pos = 5'(31 - i); // [R5] [R6] lowest index wins last
         end
      end else begin
         for (int i = 0; i < 32; i++) begin
            if (p.req[i]) p.pos = 5'(31 - i); // [R5] [R6] highest index wins last
         end
      end
   end
endmodule // irq_prio_enc

// File: logic/interrupt_combiner_unit.sv
// Dual-level interrupt combiner with vector and register port
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "irq_combiner_cfg.svh"
module interrupt_combiner_unit #(
   parameter int N_SRC = 32
) (
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic [31:0] src_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   output logic             crit_irq_o,
   output logic             noncrit_irq_o,
   output logic             pend_irq_o
);
   // Refuse a source count other than the full status word
   if (N_SRC != 32) begin : g_src_chk
      $error("N_SRC must be 32");
   end
   irq_combiner_pkg::word_t s1_r, s2_r, prev_r, stat_r, stat_nxt;
   irq_combiner_pkg::word_t en_r, crit_r, edge_r, pol_r, vbase_r, pmask_r, pstat_r;
   logic prio_r;
   irq_combiner_pkg::word_t act, rise, fall, det, enab;
   irq_prio_if pif ();
   //----------------------------------------
   // Bus decode
   //----------------------------------------
   // Strobe aimed at one register offset
   function automatic logic bus_hit(input logic       strobe,
                                    input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return strobe && (addr == ofs);
   endfunction
   logic stat_clr, pend_rd;
   // Status clear and pending read, shared by logic and checks
   assign stat_clr = bus_hit(wr_i, addr_i, `IC_STATUS_OFS);
   assign pend_rd  = bus_hit(rd_i, addr_i, `IC_PEND_OFS);
   //----------------------------------------
   // Input synchroniser
   //----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         s1_r   <= `IC_ZERO_RST;
         s2_r   <= `IC_ZERO_RST;
         prev_r <= `IC_ZERO_RST;
      end else begin
         s1_r   <= src_i;
         s2_r   <= s1_r;
         prev_r <= s2_r;
      end
   end
   //----------------------------------------
   // Detection
   //----------------------------------------
   always_comb begin
      act  = ~(s2_r ^ pol_r);                 // [R3] pol 1 = high/rising
      rise = s2_r & ~prev_r;
      fall = ~s2_r & prev_r;
      det  = (pol_r & rise) | (~pol_r & fall); // [R3]
      enab = stat_r & en_r;                    // [R7]
   end
   // Edge bits latch, level bits follow; write-one clears, set wins
   always_comb begin
      stat_nxt = stat_r;
      if (stat_clr) stat_nxt = stat_r & ~wdata_i;
      stat_nxt = (edge_r & (stat_nxt | det)) | (~edge_r & act); // [R2]
   end
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) stat_r <= `IC_ZERO_RST;
      else stat_r <= stat_nxt;
   end
   //----------------------------------------
   // Configuration registers
   //----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         en_r <= `IC_ZERO_RST;
         crit_r <= `IC_ZERO_RST;
         edge_r <= `IC_ZERO_RST;
         pol_r <= `IC_POL_RST;
         vbase_r <= `IC_ZERO_RST;
         prio_r <= 1'b0;
         pmask_r <= `IC_ZERO_RST;
      end else if (wr_i) begin
         case (addr_i)
            `IC_ENABLE_OFS: en_r    <= wdata_i;
            `IC_CRIT_OFS:   crit_r  <= wdata_i; // [R1]
            `IC_EDGE_OFS:   edge_r  <= wdata_i; // [R2]
            `IC_POL_OFS:    pol_r   <= wdata_i; // [R3]
            `IC_VBASE_OFS:  vbase_r <= wdata_i; // [R4]
            `IC_CTRL_OFS:   prio_r  <= wdata_i[`IC_CTRL_PRIO_BIT]; // [R5]
            `IC_PMASK_OFS:  pmask_r <= wdata_i;
            default: ;
         endcase
      end
   end
   //----------------------------------------
   // Vector search
   //----------------------------------------
   assign pif.req       = enab & crit_r; // [R4] [R7]
   assign pif.lsb_first = prio_r;
   // Encoder sees only enabled critical sources
   irq_prio_enc u_enc (.p(pif.enc));
   //----------------------------------------
   // Own event interrupt: sticky edges of the request lines, read clears
   //----------------------------------------
   logic crit_nxt, ncrit_nxt;
   assign crit_nxt  = |(enab & crit_r);  // [R1] [R7]
   assign ncrit_nxt = |(enab & ~crit_r); // [R1] [R7]
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) pstat_r <= `IC_ZERO_RST;
      else begin
         pstat_r[0] <= (crit_nxt & ~crit_irq_o) |
                       (pstat_r[0] & ~pend_rd);
         pstat_r[1] <= (ncrit_nxt & ~noncrit_irq_o) |
                       (pstat_r[1] & ~pend_rd);
      end
   end
   //----------------------------------------
   // Outputs and read data
   //----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         crit_irq_o    <= 1'b0;
         noncrit_irq_o <= 1'b0;
         pend_irq_o    <= 1'b0;
      end else begin
         crit_irq_o    <= crit_nxt;
         noncrit_irq_o <= ncrit_nxt;
         pend_irq_o    <= |(pstat_r & pmask_r);
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) rdata_o <= `IC_ZERO_RST;
      else if (rd_i) begin
         case (addr_i)
            `IC_STATUS_OFS: rdata_o <= stat_r; // [R7] raw state
            `IC_ENABLE_OFS: rdata_o <= en_r;
            `IC_CRIT_OFS:   rdata_o <= crit_r;
            `IC_EDGE_OFS:   rdata_o <= edge_r;
            `IC_POL_OFS:    rdata_o <= pol_r;
            `IC_VBASE_OFS:  rdata_o <= vbase_r;
            `IC_VEC_OFS:    rdata_o <= vbase_r | {25'h0, pif.pos, 2'h0}; // [R4] [R6]
            `IC_CTRL_OFS:   rdata_o <= {31'h0, prio_r};
            `IC_PEND_OFS:   rdata_o <= pstat_r;
            `IC_PMASK_OFS:  rdata_o <= pmask_r;
            default:        rdata_o <= `IC_ZERO_RST;
         endcase
      end else rdata_o <= `IC_ZERO_RST;
   end
   //----------------------------------------
   // Checks
   //----------------------------------------
   crit_line_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1]
      crit_irq_o == $past(|(stat_r & en_r & crit_r))) else $error("crit line wrong");
   ncrit_line_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      (en_r == 32'h0) |=> !noncrit_irq_o) else $error("disabled source reached line");
   edge_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R2]
      (edge_r[0] && stat_r[0] && !stat_clr) |=> stat_r[0])
      else $error("edge latch lost");
   level_pol_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R3]
      !edge_r[0] |=> stat_r[0] == ($past(s2_r[0]) == $past(pol_r[0]))) else $error("polarity");
   vec_hit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R4]
      pif.hit |-> pif.req[31 - pif.pos]) else $error("vector not pending");
   msb_first_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R5]
      (!prio_r && pif.req[31]) |-> pif.pos == 5'h00) else $error("msb priority");
   lsb_first_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R6]
      (prio_r && pif.req[0]) |-> pif.pos == 5'h1f) else $error("lsb priority");
   vec_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R4]
      (rd_i && addr_i == `IC_VEC_OFS) |=>
         rdata_o[6:2] == ($past(vbase_r[6:2]) | $past(pif.pos)))
      else $error("vector read");
   ncrit_mask_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      ((en_r & ~crit_r) == 32'h0) |=> !noncrit_irq_o) else $error("disabled noncrit");
   //----------------------------------------
   // Checks: multi-step paths
   //----------------------------------------
   // Level source 0 routed critical, active, and no write to move its setup
   sequence lvl_src0_s;
      !edge_r[0] && en_r[0] && crit_r[0] && !wr_i && (s2_r[0] == pol_r[0]);
   endsequence
   // Edge source 0 sees its selected transition
   sequence edge_det0_s;
      edge_r[0] && det[0];
   endsequence
   // Edge source 0 cleared by software with no new transition
   sequence edge_clr0_s;
      edge_r[0] && stat_clr && wdata_i[0] && !det[0];
   endsequence
   // Critical line about to rise
   sequence crit_rise_s;
      crit_nxt && !crit_irq_o;
   endsequence
   // Source to line, edge latch set and clear
   lvl_path_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1] [R3]
      lvl_src0_s |-> ##2 crit_irq_o) else $error("level source missed line");
   edge_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R2] [R3]
      edge_det0_s |=> stat_r[0]) else $error("edge not latched");
   edge_clr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R2]
      edge_clr0_s |=> !stat_r[0]) else $error("edge clear lost");
   crit_mask_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      ((en_r & crit_r) == 32'h0) |=> !crit_irq_o) else $error("disabled crit");
   ncrit_rtd_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R1]
      noncrit_irq_o == $past(|(stat_r & en_r & ~crit_r))) else $error("noncrit line wrong");
   // No hit gives position zero; a winner has no better pending source on its side
   vec_none_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R4]
      !pif.hit |-> pif.pos == 5'h00) else $error("vector without hit");
   msb_best_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R5] [R6]
      (pif.hit && !prio_r) |-> (pif.req >> (32 - pif.pos)) == 32'h0)
      else $error("msb winner");
   lsb_best_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R5] [R6]
      (pif.hit && prio_r) |-> (pif.req << (pif.pos + 1)) == 32'h0)
      else $error("lsb winner");
   // Own event status, its line and the read port
   pend_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      crit_rise_s |=> pstat_r[0]) else $error("pend set lost");
   pend_clr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (pend_rd && !(crit_nxt && !crit_irq_o)) |=> !pstat_r[0]) else $error("pend kept");
   pend_line_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      pend_irq_o == $past(|(pstat_r & pmask_r))) else $error("pend line wrong");
   rd_idle_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !rd_i |=> rdata_o == `IC_ZERO_RST) else $error("read data not idle");
   stat_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R7]
      pend_rd_stat_hit(rd_i, addr_i) |=> rdata_o == $past(stat_r)) else $error("status read");
   // Read strobe aimed at the status register
   function automatic logic pend_rd_stat_hit(input logic       strobe,
                                             input logic [7:0] addr);
      return bus_hit(strobe, addr, `IC_STATUS_OFS);
   endfunction
endmodule // interrupt_combiner_unit

// File: test/irq_host_model.sv
// Host core model: counts requests seen on its two interrupt inputs
`timescale 1ns/1ns
module irq_host_model (
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   input  wire logic crit_i,
   input  wire logic noncrit_i,
   output int        crit_cnt_o,
   output int        noncrit_cnt_o
);
   logic crit_q, noncrit_q;
   // Count rising edges of each request line, as a core taking the request would
   always_ff @(posedge sys_clk_i) begin
      crit_q <= crit_i;
      noncrit_q <= noncrit_i;
      if (!resetn_i) begin
         crit_cnt_o <= 0;
         noncrit_cnt_o <= 0;
      end else begin
         if (crit_i && !crit_q) crit_cnt_o <= crit_cnt_o + 1;
         if (noncrit_i && !noncrit_q) noncrit_cnt_o <= noncrit_cnt_o + 1;
      end
   end
endmodule // irq_host_model

// File: test/tb.sv
// Self-checking bench for the dual-level interrupt combiner
`timescale 1ns/1ns
`include "irq_combiner_cfg.svh"
module tb;
   typedef irq_combiner_pkg::word_t w_t;
   logic sys_clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   w_t src_i = 32'h0, wdata_i = 32'h0, rdata_o, en, cr, pol, base, st, hits, d;
   logic crit_irq_o, noncrit_irq_o, pend_irq_o, lsb;
   int error_cnt = 0, compares = 0, seed = 62, cycles = 0, pos, c_cnt, n_cnt, c0, n0;
   interrupt_combiner_unit i_interrupt_combiner_unit (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .src_i(src_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .crit_irq_o(crit_irq_o),
      .noncrit_irq_o(noncrit_irq_o), .pend_irq_o(pend_irq_o));
   irq_host_model i_irq_host_model (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .crit_i(crit_irq_o), .noncrit_i(noncrit_irq_o), .crit_cnt_o(c_cnt), .noncrit_cnt_o(n_cnt));
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Hang guard
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic wr(input logic [7:0] a, input w_t v);
      addr_i <= a; wdata_i <= v; wr_i <= 1'b1; @(posedge sys_clk_i);
      wr_i <= 1'b0; @(posedge sys_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output w_t v);
      addr_i <= a; rd_i <= 1'b1; @(posedge sys_clk_i);
      rd_i <= 1'b0; @(posedge sys_clk_i); v = rdata_o;
   endtask
   task automatic chk(input string nm, input w_t e, input w_t g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic final_report();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge sys_clk_i);
      resetn_i <= 1'b1; @(posedge sys_clk_i);
      rd(`IC_POL_OFS, d); chk("pol_rst", `IC_POL_RST, d);
      rd(`IC_ENABLE_OFS, d); chk("en_rst", `IC_ZERO_RST, d);
      wr(8'h40, 32'hffff_ffff); rd(8'h40, d); chk("unmapped", 32'h0, d);
      // Level sources, random routing, polarity, enable and priority end
      for (int n = 0; n < 24; n++) begin
         en = $random(seed); cr = $random(seed); pol = $random(seed);
         base = $random(seed); lsb = n[0];
         if (n < 2) en = 32'h0;
         if (n == 2 || n == 3) en = 32'h1;
         if (n == 4 || n == 5) en = 32'h8000_0001;
         if (n < 6) cr = 32'hffff_ffff;
         wr(`IC_ENABLE_OFS, en); wr(`IC_CRIT_OFS, cr); wr(`IC_POL_OFS, pol);
         wr(`IC_VBASE_OFS, base); wr(`IC_CTRL_OFS, {31'h0, lsb});
         src_i <= $random(seed); repeat (5) @(posedge sys_clk_i);
         st = ~(src_i ^ pol); hits = st & en & cr; pos = 0;
         rd(`IC_STATUS_OFS, d); chk("status", st, d);
         chkb("crit", |hits, crit_irq_o);
         chkb("noncrit", |(st & en & ~cr), noncrit_irq_o);
         for (int k = 0; k < 32; k++) begin
            if (lsb ? hits[31 - k] : hits[k]) pos = lsb ? k : 31 - k;
         end
         rd(`IC_VEC_OFS, d); chk("vector", base | (pos << 2), d);
      end
      // Edge sources: rising and falling latches, clear, pending event
      src_i <= 32'ha; wr(`IC_ENABLE_OFS, 32'hf); wr(`IC_CRIT_OFS, 32'h1);
      wr(`IC_POL_OFS, 32'h5); wr(`IC_EDGE_OFS, 32'hf); wr(`IC_STATUS_OFS, 32'hf);
      wr(`IC_PMASK_OFS, 32'h1); rd(`IC_PEND_OFS, d); c0 = c_cnt; n0 = n_cnt;
      chkb("crit_idle", 1'b0, crit_irq_o);
      src_i <= 32'h5; repeat (5) @(posedge sys_clk_i);
      src_i <= 32'h0; repeat (5) @(posedge sys_clk_i);
      rd(`IC_STATUS_OFS, d); chk("edge_stat", 32'hffff_ffff, d);
      chk("host_crit", c0 + 1, c_cnt);
      chk("host_noncrit", n0 + 1, n_cnt);
      chkb("pend_irq", 1'b1, pend_irq_o);
      rd(`IC_PEND_OFS, d); chk("pend_bit", 32'h1, d & 32'h1);
      @(posedge sys_clk_i); chkb("pend_clr", 1'b0, pend_irq_o);
      wr(`IC_STATUS_OFS, 32'h1); repeat (3) @(posedge sys_clk_i);
      rd(`IC_STATUS_OFS, d); chk("edge_clr", 32'hffff_fffe, d);
      chkb("crit_off", 1'b0, crit_irq_o);
      chkb("noncrit_on", 1'b1, noncrit_irq_o);
      final_report();
   end
endmodule // tb
